/* design/ogawb_pkg.sv */
// Package of constants and types for the overhead global action word builder
package ogawb_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OGAWB_CTRL_OFS = 8'h00;
  localparam logic [7:0] OGAWB_STEP_OFS = 8'h04;
  localparam logic [7:0] OGAWB_CMD_OFS = 8'h08;
  localparam logic [7:0] OGAWB_STAT_OFS = 8'h0c;
  localparam logic [7:0] OGAWB_WLO_OFS = 8'h10;
  localparam logic [7:0] OGAWB_WHI_OFS = 8'h14;

  // ************************************************************
  // Control, command and status register field positions
  // ************************************************************
  localparam int OGAWB_CTRL_WT_POS = 0;
  localparam int OGAWB_CTRL_CC_POS = 2;
  localparam int OGAWB_CTRL_AC_POS = 4;
  localparam int OGAWB_CTRL_BI_POS = 8;
  localparam int OGAWB_CTRL_LW_POS = 9;
  localparam int OGAWB_CTRL_OT_POS = 10;
  localparam int OGAWB_CTRL_VAR_POS = 12;
  localparam int OGAWB_CMD_BUILD_POS = 0;
  localparam int OGAWB_STAT_BUSY_POS = 0;
  localparam int OGAWB_STAT_DONE_POS = 1;

  // ************************************************************
  // Field widths and word layout
  // ************************************************************
  localparam int OGAWB_WORD_W = 40;
  localparam int OGAWB_DATA_W = 28;
  localparam int OGAWB_PAR_W = 12;
  localparam int OGAWB_STEP_W = 12;
  localparam int OGAWB_SPARE_ACC_W = 15;
  localparam int OGAWB_SPARE_REG_W = 4;

  // ************************************************************
  // Fixed field values
  // ************************************************************
  localparam logic [2:0] OGAWB_OT_GLOBAL = 3'h4;
  localparam logic [2:0] OGAWB_OT_SYS1 = 3'h6;
  localparam logic [2:0] OGAWB_OT_SYS2 = 3'h7;
  localparam logic [14:0] OGAWB_SPARE_ACC = 15'h0000;
  localparam logic [3:0] OGAWB_SPARE_REG = 4'h0;
  // Parity generator polynomial, low twelve terms
  localparam logic [11:0] OGAWB_PAR_POLY = 12'h539;

  // ************************************************************
  // Reset values and bus answers
  // ************************************************************
  localparam logic [12:0] OGAWB_CTRL_RST = 13'h0000;
  localparam logic [11:0] OGAWB_STEP_RST = 12'h000;
  localparam logic [1:0] OGAWB_RESP_OKAY = 2'h0;
  localparam logic [1:0] OGAWB_RESP_SLVERR = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    OGAWB_OTSEL_GLOBAL = 2'b00,
    OGAWB_OTSEL_SYS1 = 2'b01,
    OGAWB_OTSEL_SYS2 = 2'b10
  } ogawb_otsel_t;

  typedef enum logic [1:0] {
    OGAWB_ST_IDLE = 2'b00,
    OGAWB_ST_CALC = 2'b01,
    OGAWB_ST_ASM = 2'b10,
    OGAWB_ST_OFFER = 2'b11
  } ogawb_state_t;
endpackage : ogawb_pkg

/* design/ogawb_parity.sv */
// Registered parity generator for one overhead word
`timescale 1ns/1ps
`default_nettype none
module ogawb_parity
  import ogawb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic load,
  input wire logic [ogawb_pkg::OGAWB_DATA_W-1:0] data,
  output logic [ogawb_pkg::OGAWB_PAR_W-1:0] parity
);
  typedef struct packed {
    logic [OGAWB_PAR_W-1:0] par;
  } ogawb_par_state_t;

  ogawb_par_state_t s_q;
  ogawb_par_state_t s_d;

  // Polynomial division, message bits first
  function automatic logic [OGAWB_PAR_W-1:0] ogawb_div(input logic [OGAWB_DATA_W-1:0] d);
    logic [OGAWB_PAR_W-1:0] r;
    logic fb;
    r = '0;
    fb = 1'b0;
    for (int i = OGAWB_DATA_W - 1; i >= 0; i--)
    begin
      fb = d[i] ^ r[OGAWB_PAR_W-1];
      r = {r[OGAWB_PAR_W-2:0], 1'b0} ^ (fb ? OGAWB_PAR_POLY : '0);
    end
    return r;
  endfunction : ogawb_div

  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.par = ogawb_div(data);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign parity = s_q.par;
endmodule : ogawb_parity
`default_nettype wire

/* design/ogawb_builder.sv */
// Overhead global action word builder with AXI4-Lite register slave
// Functional notes
// - Two-bit word type field in every word
// - Two-bit colour code from configuration
// - Four-bit global action code field
// - Access word carries configured busy-idle bit
// - Fifteen spare bits in access word, four in registration word, forced to fixed values
// - Last-word flag one closes the train
// - Overhead type 100, 110 or 111
// - Parity computed internally, never from configuration
// - Registration variant carries twelve-bit increment
`timescale 1ns/1ps
`default_nettype none
module ogawb_builder
  import ogawb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ogawb_pkg::OGAWB_WORD_W-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready
);
  import ogawb_pkg::*;

  // ************************************************************
  // State record
  // ************************************************************
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [12:0] ctrl;
    logic [OGAWB_STEP_W-1:0] step;
    ogawb_state_t fsm;
    logic done;
    logic [OGAWB_WORD_W-1:0] word;
  } ogawb_state_rec_t;

  ogawb_state_rec_t s_q;
  ogawb_state_rec_t s_d;
  logic [OGAWB_PAR_W-1:0] par;
  logic par_load;
  logic [OGAWB_DATA_W-1:0] msg;
  logic do_write;
  logic do_read;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_step;
  logic [31:0] stat_word;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] ogawb_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : ogawb_merge

  // Overhead type selection to its three-bit code
  function automatic logic [2:0] ogawb_ot_code(input logic [1:0] sel);
    logic [2:0] c;
    case (ogawb_otsel_t'(sel))
      OGAWB_OTSEL_SYS1: c = OGAWB_OT_SYS1;
      OGAWB_OTSEL_SYS2: c = OGAWB_OT_SYS2;
      default: c = OGAWB_OT_GLOBAL;
    endcase
    return c;
  endfunction : ogawb_ot_code

  // Message part of the word, parity excluded
  function automatic logic [OGAWB_DATA_W-1:0] ogawb_msg(input logic [12:0] c,
                                                        input logic [OGAWB_STEP_W-1:0] stp);
    logic [OGAWB_DATA_W-1:0] m;
    logic [2:0] ot;
    ot = ogawb_ot_code(c[OGAWB_CTRL_OT_POS +: 2]);
    if (c[OGAWB_CTRL_VAR_POS])
    begin
      m = {c[OGAWB_CTRL_WT_POS +: 2], c[OGAWB_CTRL_CC_POS +: 2], c[OGAWB_CTRL_AC_POS +: 4],
           stp, OGAWB_SPARE_REG, c[OGAWB_CTRL_LW_POS], ot};
    end
    else
    begin
      m = {c[OGAWB_CTRL_WT_POS +: 2],
           c[OGAWB_CTRL_CC_POS +: 2],
           c[OGAWB_CTRL_AC_POS +: 4],
           c[OGAWB_CTRL_BI_POS],
           OGAWB_SPARE_ACC,
           c[OGAWB_CTRL_LW_POS],
           ot};
    end
    return m;
  endfunction : ogawb_msg

  // ************************************************************
  // Parity generator
  // ************************************************************
  assign msg = ogawb_msg(s_q.ctrl, s_q.step);
  assign par_load = (s_q.fsm == OGAWB_ST_CALC);

  ogawb_parity u_parity (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .load(par_load),
    .data(msg),
    .parity(par)
  );

  // ************************************************************
  // Bus handshakes
  // ************************************************************
  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  // Writes wait out the parity load so parity always matches the message
  assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid && (s_q.fsm != OGAWB_ST_CALC);
  assign do_read = s_axi_arvalid && !s_q.rvalid;
  assign wr_ctrl = ogawb_merge({19'h00000, s_q.ctrl}, s_q.w_data, s_q.w_strb);
  assign wr_step = ogawb_merge({20'h00000, s_q.step}, s_q.w_data, s_q.w_strb);
  assign stat_word = {30'h00000000, s_q.done, (s_q.fsm != OGAWB_ST_IDLE)};

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    // Address and data captured in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end

    // Register writes
    if (do_write)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = OGAWB_RESP_OKAY;
      if (s_q.aw_addr == OGAWB_CTRL_OFS)
      begin
        s_d.ctrl = wr_ctrl[12:0];
      end
      else if (s_q.aw_addr == OGAWB_STEP_OFS)
      begin
        s_d.step = wr_step[OGAWB_STEP_W-1:0];
      end
      else if (s_q.aw_addr == OGAWB_CMD_OFS)
      begin
        if (s_q.w_strb[0] && s_q.w_data[OGAWB_CMD_BUILD_POS] && s_q.fsm == OGAWB_ST_IDLE)
        begin
          s_d.fsm = OGAWB_ST_CALC;
        end
      end
      else if (s_q.aw_addr == OGAWB_STAT_OFS)
      begin
        if (s_q.w_strb[0] && s_q.w_data[OGAWB_STAT_DONE_POS])
        begin
          s_d.done = 1'b0;
        end
      end
      else if (s_q.aw_addr == OGAWB_WLO_OFS || s_q.aw_addr == OGAWB_WHI_OFS)
      begin
        s_d.bresp = OGAWB_RESP_OKAY;
      end
      else
      begin
        s_d.bresp = OGAWB_RESP_SLVERR;
      end
    end

    // Register reads
    if (do_read)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = OGAWB_RESP_OKAY;
      if (s_axi_araddr == OGAWB_CTRL_OFS)
      begin
        s_d.rdata = {19'h00000, s_q.ctrl};
      end
      else if (s_axi_araddr == OGAWB_STEP_OFS)
      begin
        s_d.rdata = {20'h00000, s_q.step};
      end
      else if (s_axi_araddr == OGAWB_CMD_OFS)
      begin
        s_d.rdata = 32'h00000000;
      end
      else if (s_axi_araddr == OGAWB_STAT_OFS)
      begin
        s_d.rdata = stat_word;
      end
      else if (s_axi_araddr == OGAWB_WLO_OFS)
      begin
        s_d.rdata = s_q.word[31:0];
      end
      else if (s_axi_araddr == OGAWB_WHI_OFS)
      begin
        s_d.rdata = {24'h000000, s_q.word[OGAWB_WORD_W-1:32]};
      end
      else
      begin
        s_d.rdata = 32'h00000000;
        s_d.rresp = OGAWB_RESP_SLVERR;
      end
    end

    // Word build sequence
    case (s_q.fsm)
      OGAWB_ST_CALC:
      begin
        s_d.fsm = OGAWB_ST_ASM;
      end
      OGAWB_ST_ASM:
      begin
        s_d.word = {msg, par};
        s_d.fsm = OGAWB_ST_OFFER;
      end
      OGAWB_ST_OFFER:
      begin
        if (word_ready)
        begin
          s_d.fsm = OGAWB_ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      default:
      begin
      end
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.ctrl <= OGAWB_CTRL_RST;
      s_q.step <= OGAWB_STEP_RST;
      s_q.fsm <= OGAWB_ST_IDLE;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign word_data = s_q.word;
  assign word_valid = (s_q.fsm == OGAWB_ST_OFFER);
endmodule : ogawb_builder
`default_nettype wire

/* verif/ogawb_props.sv */
// Port checker for the overhead global action word builder
`timescale 1ns/1ps
`default_nettype none
module ogawb_props
  import ogawb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ogawb_pkg::OGAWB_WORD_W-1:0] word_data,
  input wire logic word_valid,
  input wire logic word_ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic logic [11:0] par(input logic [27:0] m);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 27; i >= 0; i--)
      r = {r[10:0], 1'b0} ^ ((m[i] ^ r[11]) ? OGAWB_PAR_POLY : 12'h000);
    return r;
  endfunction : par

  word_hold_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("word changed before taken");
  ohd_code_a: assert property (word_valid |-> word_data[14:12] inside {3'h4, 3'h6, 3'h7})
    else $error("bad overhead type");
  spare_zero_a: assert property (word_valid |-> word_data[19:16] == 4'h0)
    else $error("spare bits not fixed");
  parity_self_a: assert property (word_valid |-> word_data[11:0] == par(word_data[39:12]))
    else $error("parity mismatch");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  wr_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  cover property (word_valid && word_ready);
  cover property (s_axi_bvalid && s_axi_bresp == OGAWB_RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : ogawb_props
`default_nettype wire

/* verif/ogawb_sink.sv */
// Transmitter model that takes built words promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module ogawb_sink
  import ogawb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic word_valid,
  input wire logic [ogawb_pkg::OGAWB_WORD_W-1:0] word_data,
  output logic word_ready,
  output logic [ogawb_pkg::OGAWB_WORD_W-1:0] last_word,
  output logic [7:0] seen
);
  logic [1:0] wait_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word_ready <= 1'b0;
      wait_q <= 2'h0;
      last_word <= '0;
      seen <= 8'h00;
    end
    else if (word_valid && word_ready)
    begin
      word_ready <= 1'b0;
      wait_q <= 2'h0;
      last_word <= word_data;
      seen <= seen + 8'h01;
    end
    else
    begin
      // Slow mode holds word_ready low for four cycles of word_valid
      wait_q <= word_valid ? wait_q + 2'h1 : 2'h0;
      word_ready <= word_valid && (!slow || wait_q == 2'h3);
    end
  end
endmodule : ogawb_sink
`default_nettype wire

/* verif/ogawb_builder_test.sv */
// Self-checking bench for the word builder
`timescale 1ns/1ps
`default_nettype none
module ogawb_builder_test;
  import ogawb_pkg::*;
  logic aclk, aresetn, ce, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr, seen, k;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, word_valid, word_ready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [39:0] word_data, last_word, e;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  typedef struct {logic [12:0] ctrl; logic [11:0] step; logic [27:0] msg;} ogawb_row_t;
  ogawb_row_t rows[4] = '{'{13'h0397, 12'h000, 28'hd98000c}, '{13'h0468, 12'h000, 28'h2600006},
    '{13'h1b2d, 12'h064, 28'h720640f}, '{13'h1d00, 12'hfff, 28'h00fff04}};

  ogawb_builder dut (.*);
  ogawb_sink snk (.*);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [11:0] par(input logic [27:0] m);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 27; i >= 0; i--)
      r = {r[10:0], 1'b0} ^ ((m[i] ^ r[11]) ? OGAWB_PAR_POLY : 12'h000);
    return r;
  endfunction : par

  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, b;
    pa = 1;
    pw = 1;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b)
    begin
      @(negedge aclk);
      b = s_axi_bvalid && ce;
      rsp = s_axi_bresp;
      if (s_axi_awready && ce)
        pa = 0;
      if (s_axi_wready && ce)
        pw = 0;
      @(posedge aclk);
      if (!pa)
        s_axi_awvalid <= 1'b0;
      if (!pw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic p, b;
    p = 1;
    b = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b)
    begin
      @(negedge aclk);
      b = s_axi_rvalid && ce;
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      if (s_axi_arready && ce)
        p = 0;
      @(posedge aclk);
      if (!p)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic build_wait;
    k = seen;
    wr(OGAWB_CMD_OFS, 32'h1);
    while (seen == k)
      @(negedge aclk);
    @(posedge aclk);
  endtask : build_wait

  // ****************************************
  // Clock, timeout and bind
  // ****************************************
  initial
  begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      final_report;
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    ce = 1;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OGAWB_CTRL_OFS);
    chk(rd_d, 40'h0);
    for (int i = 0; i < 4; i++)
    begin
      slow <= i[0];
      e = {rows[i].msg, par(rows[i].msg)};
      wr(OGAWB_CTRL_OFS, {19'h0, rows[i].ctrl});
      wr(OGAWB_STEP_OFS, {20'h0, rows[i].step});
      build_wait;
      chk(last_word, e);
      rd(OGAWB_WHI_OFS);
      chk(rd_d, {32'h0, e[39:32]});
      rd(OGAWB_WLO_OFS);
      chk(rd_d, e[31:0]);
      rd(OGAWB_STAT_OFS);
      chk(rd_d[1:0], 2'b10);
      wr(OGAWB_STAT_OFS, 32'h2);
      rd(OGAWB_STAT_OFS);
      chk(rd_d[1:0], 2'b00);
    end
    wr(8'h20, 32'hffffffff);
    chk(rsp, OGAWB_RESP_SLVERR);
    rd(8'h20);
    chk({rsp, rd_d}, {OGAWB_RESP_SLVERR, 32'h0});
    // Word store is read-only, build while busy is dropped
    wr(OGAWB_WLO_OFS, 32'hfff);
    rd(OGAWB_WLO_OFS);
    chk(rd_d, e[31:0]);
    slow <= 1'b1;
    k = seen;
    wr(OGAWB_CMD_OFS, 32'h1);
    wr(OGAWB_CMD_OFS, 32'h1);
    while (seen == k)
      @(negedge aclk);
    repeat (20) @(posedge aclk);
    chk(seen, k + 8'h1);
    chk(last_word, e);
    // Clock enable low holds off a build command
    k = seen;
    ce <= 1'b0;
    fork
      wr(OGAWB_CMD_OFS, 32'h1);
      begin
        repeat (6) @(negedge aclk);
        chk(s_axi_bvalid, 1'b0);
        chk(word_valid, 1'b0);
        chk(seen, k);
        @(posedge aclk);
        ce <= 1'b1;
      end
    join
    while (seen == k)
      @(negedge aclk);
    @(posedge aclk);
    chk(last_word, e);
    // Reset in mid-run restores register defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OGAWB_CTRL_OFS);
    chk(rd_d, 40'h0);
    rd(OGAWB_STEP_OFS);
    chk(rd_d, 40'h0);
    rd(OGAWB_WLO_OFS);
    chk(rd_d, 40'h0);
    rd(OGAWB_STAT_OFS);
    chk(rd_d, 40'h0);
    final_report;
  end
endmodule : ogawb_builder_test

bind ogawb_builder ogawb_props props_i (.*);
`default_nettype wire
